//--- logic/t2c_timer2_control.sv
// Purpose: timer-2 control/status register and the counter it steers
// Assumes: pins synchronous to clk; interrupt enable comes from outside
// Notes:   unmapped reads return zero; count writes beat counting, overflow flag sets beat control writes
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module t2c_timer2_control
   import t2c_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   input  wire logic       triggerDirectionPin,
   input  wire logic       externalCountPin,
   input  wire logic       timer2IntEnable,
   input  wire logic       timer1Overflow,
   output logic            timer2Irq,
   output logic            rxClockTick,
   output logic            txClockTick,
   output logic            timer2BaudTick
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]  ctrl;       // timer2_control
   logic [1:0]  modeReg;    // timer_mode_control, low two bits
   logic [15:0] count;      // 16-bit count
   logic [15:0] capPair;    // capture/reload pair
   logic [3:0]  prescale;   // machine-cycle divider
   logic        stateTog;   // state-time divider
   logic [7:0]  next_ctrl;
   logic [15:0] next_count;
   logic [7:0]  next_rdata;
   t2c_mode_e   mode;       // decoded operating mode

   t2c_edge_if trigIf ();   // trigger/direction pin
   t2c_edge_if cntIf ();    // external count pin

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire wrCtrl = regWrite && (regAddr == ADDR_CTRL); // R03
   wire wrMode = regWrite && (regAddr == ADDR_MODE);
   wire wrCapL = regWrite && (regAddr == ADDR_CAPL);
   wire wrCapH = regWrite && (regAddr == ADDR_CAPH);
   wire wrCntL = regWrite && (regAddr == ADDR_CNTL);
   wire wrCntH = regWrite && (regAddr == ADDR_CNTH);
   wire wrCnt  = wrCntL || wrCntH;

   // ---------------------------------------------------------------
   // mode and tick decode
   // ---------------------------------------------------------------
   wire down_count_enable    = modeReg[M_DOWN_COUNT_ENABLE];
   wire run     = ctrl[B_RUN];
   wire exen    = ctrl[B_EXEN];
   wire mcTick  = (prescale == PRE_LAST);
   wire stTick  = stateTog;
   assign mode  = t2c_mode(ctrl, down_count_enable); // R13 R14
   wire isBaud  = (mode == MD_BAUD);
   wire isCap   = (mode == MD_CAPTURE);
   wire isUpDn  = (mode == MD_UPDOWN);
   // timer input runs at state rate only in serial clock mode
   wire timeTick = isBaud ? stTick : mcTick;
   wire srcTick  = ctrl[B_CT] ? cntIf.fallSeen : timeTick; // R12
   wire cntStep  = run && srcTick; // R11
   // direction pin counts only in up/down mode, up by default
   wire countUp  = !isUpDn || triggerDirectionPin; // R16 R17
   wire trigEvt  = exen && trigIf.fallSeen && !isUpDn; // R10
   wire ovfUp    = cntStep && countUp && (count == CNT_MAX);
   wire undf     = cntStep && !countUp && (count == capPair);
   wire ovfEvt   = ovfUp || undf;
   wire trigLoad = trigEvt && (mode == MD_RELOAD); // R13
   wire capture  = trigEvt && isCap; // R13 R15
   // serial clock mode never sets the overflow flag
   wire setOvf   = ovfEvt && !isBaud; // R04 R05
   wire setExt   = trigEvt; // R06
   wire togExt   = ovfEvt && isUpDn;

   // ---------------------------------------------------------------
   // pin samplers
   // ---------------------------------------------------------------
   assign trigIf.sampleTick = mcTick;
   assign trigIf.pinLevel   = triggerDirectionPin;
   assign cntIf.sampleTick  = mcTick;
   assign cntIf.pinLevel    = externalCountPin;

   t2c_fall_detect u_trig (
      .clk     (clk),
      .rst_n   (rst_n),
      .edge_io (trigIf)
   );

   t2c_fall_detect u_cnt (
      .clk     (clk),
      .rst_n   (rst_n),
      .edge_io (cntIf)
   );

   // ---------------------------------------------------------------
   // capture/reload pair
   // ---------------------------------------------------------------
   t2c_reload_pair u_pair (
      .clk          (clk),
      .rst_n        (rst_n),
      .writeLow     (wrCapL),
      .writeHigh    (wrCapH),
      .writeData    (regWdata),
      .capture      (capture),
      .captureValue (count),
      .pairValue    (capPair)
   );

   // ---------------------------------------------------------------
   // control register next value
   // ---------------------------------------------------------------
   // hardware set wins over a software clear in the same cycle
   always_comb begin
      next_ctrl = wrCtrl ? regWdata : ctrl;
      next_ctrl[B_EXT] = next_ctrl[B_EXT] ^ togExt; // 17th bit in up/down
      if (setOvf) begin
         next_ctrl[B_OVF] = 1'b1; // R04
      end
      if (setExt) begin
         next_ctrl[B_EXT] = 1'b1; // R06
      end
   end

   // ---------------------------------------------------------------
   // counter next value
   // ---------------------------------------------------------------
   // a software write beats counting so a loaded value is never lost
   always_comb begin
      next_count = count;
      if (wrCnt) begin
         if (wrCntL) begin
            next_count[7:0] = regWdata;
         end
         if (wrCntH) begin
            next_count[15:8] = regWdata;
         end
      end else if (trigLoad) begin
         next_count = capPair; // R13 R15
      end else if (ovfEvt) begin
         if (isCap) begin
            next_count = CNT_ZERO; // plain wrap in capture mode
         end else if (undf) begin
            next_count = CNT_MAX;
         end else begin
            next_count = capPair; // R14 R15
         end
      end else if (cntStep) begin
         next_count = countUp ? count + CNT_ONE : count - CNT_ONE;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // unmapped addresses answer zero, a legal choice for any value
   always_comb begin
      unique case (regAddr)
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_MODE: next_rdata = {6'h00, modeReg};
         ADDR_CAPL: next_rdata = capPair[7:0];
         ADDR_CAPH: next_rdata = capPair[15:8];
         ADDR_CNTL: next_rdata = count[7:0];
         ADDR_CNTH: next_rdata = count[15:8];
         default:   next_rdata = BYTE_ZERO; // R01
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // control, mode and counter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl    <= CTRL_RESET; // R03
         modeReg <= MODE_RESET; // R16
         count   <= CNT_ZERO;
      end else begin
         ctrl  <= next_ctrl;
         count <= next_count;
         if (wrMode) begin
            modeReg <= regWdata[1:0];
         end
      end
   end

   // machine-cycle and state-time dividers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prescale <= PRE_ZERO;
         stateTog <= 1'b0;
      end else begin
         prescale <= mcTick ? PRE_ZERO : prescale + 4'h1;
         stateTog <= ~stateTog;
      end
   end

   // read data stands only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= BYTE_ZERO;
      end else begin
         regRdata <= regRead ? next_rdata : BYTE_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // serial clocks and interrupt request
   // ---------------------------------------------------------------
   assign timer2BaudTick = ovfUp && isBaud;
   assign rxClockTick = ctrl[B_RCLK] ? timer2BaudTick : timer1Overflow; // R08
   assign txClockTick = ctrl[B_TRANSMIT_CLOCK_SELECT] ? timer2BaudTick : timer1Overflow; // R09
   // external flag raises no request in up/down mode
   wire extReq = ctrl[B_EXT] && !down_count_enable; // R07
   assign timer2Irq = timer2IntEnable && (ctrl[B_OVF] || extReq); // R07

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_ctrl_reset_zero: assert property ( // R03
      @(posedge clk) !rst_n |=> (ctrl == CTRL_RESET) && !modeReg[M_DOWN_COUNT_ENABLE])
      else $error("control or mode not cleared by reset");
   chk_ovf_baud_blocked: assert property ( // R05
      @(posedge clk) disable iff (!rst_n)
      (isBaud && !wrCtrl && !ctrl[B_OVF]) |=> !ctrl[B_OVF])
      else $error("overflow flag set in serial clock mode");
   chk_ovf_flag_sticky: assert property ( // R04
      @(posedge clk) disable iff (!rst_n)
      (ctrl[B_OVF] && !wrCtrl) |=> ctrl[B_OVF])
      else $error("overflow flag cleared by hardware");
   chk_ovf_flag_sets: assert property ( // R04
      @(posedge clk) disable iff (!rst_n)
      (ovfUp && !isBaud) |=> ctrl[B_OVF])
      else $error("overflow flag missed an overflow");
   chk_ext_trigger_off: assert property ( // R10
      @(posedge clk) disable iff (!rst_n)
      (!exen && !isUpDn && !wrCtrl && !ctrl[B_EXT]) |=> !ctrl[B_EXT])
      else $error("external flag set with trigger disabled");
   chk_ext_irq_gate: assert property ( // R07
      @(posedge clk) disable iff (!rst_n)
      (ctrl[B_EXT] && timer2IntEnable) |-> (timer2Irq == (!down_count_enable || ctrl[B_OVF])))
      else $error("external flag request gating wrong");
   chk_rx_source_sel: assert property ( // R08
      @(posedge clk) disable iff (!rst_n)
      !ctrl[B_RCLK] |-> (rxClockTick == timer1Overflow))
      else $error("receive clock not from timer 1");
   chk_tx_source_sel: assert property ( // R09
      @(posedge clk) disable iff (!rst_n)
      (ctrl[B_TRANSMIT_CLOCK_SELECT] && !timer2BaudTick) |-> !txClockTick)
      else $error("transmit clock not from timer 2");
   chk_stopped_holds: assert property ( // R11
      @(posedge clk) disable iff (!rst_n)
      (!run && !wrCnt && !trigLoad) |=> (count == $past(count)))
      else $error("count moved while stopped");
   chk_capture_value: assert property ( // R15
      @(posedge clk) disable iff (!rst_n)
      (capture && !wrCapL && !wrCapH) |=> (capPair == $past(count)))
      else $error("capture did not store the count");
   chk_baud_reload: assert property ( // R14
      @(posedge clk) disable iff (!rst_n)
      (timer2BaudTick && !wrCnt) |=> (count == $past(capPair)))
      else $error("serial clock overflow did not reload");
endmodule

//--- logic/t2c_pkg.sv
// Purpose: constants, types and mode decode for the timer-2 control block
// Assumes: 8-bit register port, one 25 MHz core clock, synchronous pins
// Notes:   offsets are byte addresses in the special-function space
// Behaviour
// R01: unoccupied addresses read zero, writes ignored
// R02: software never writes ones to unlisted addresses
// R03: control register at C8, reset zero
// R04: bit 7 overflow flag, sticky, software clears
// R05: no overflow flag while either serial clock selected
// R06: bit 6 external flag set by trigger event
// R07: external flag interrupts, except in up/down mode; the code masks it whenever down-count enable is set
// R08: bit 5 picks receive clock source
// R09: bit 4 picks transmit clock source
// R10: bit 3 enables trigger pin, else ignored
// R11: bit 2 runs or stops the timer
// R12: bit 1 selects timer or pin counting
// R13: bit 0 selects capture or auto-reload
// R14: serial clock mode forces reload on overflow
// R15: capture pair captures or supplies reload value
// R16: down-count enable resets zero, pin sets direction
// R17: outside party drives the trigger/direction pin
// R18: falling edge is high sample then low
package t2c_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'hC8; // timer2_control
   localparam logic [7:0] ADDR_MODE = 8'hC9; // timer_mode_control
   localparam logic [7:0] ADDR_CAPL = 8'hCA; // capture_reload_low
   localparam logic [7:0] ADDR_CAPH = 8'hCB; // capture_reload_high
   localparam logic [7:0] ADDR_CNTL = 8'hCC; // count low byte
   localparam logic [7:0] ADDR_CNTH = 8'hCD; // count high byte
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int B_OVF  = 7; // overflow_flag
   localparam int B_EXT  = 6; // external_trigger_flag
   localparam int B_RCLK = 5; // receive clock select
   localparam int B_TRANSMIT_CLOCK_SELECT = 4; // transmit_clock_select
   localparam int B_EXEN = 3; // external_trigger_enable
   localparam int B_RUN  = 2; // run_control
   localparam int B_CT   = 1; // counter_timer_select
   localparam int B_CPRL = 0; // capture_reload_select
   localparam int M_DOWN_COUNT_ENABLE = 0; // down_count_enable
   // ---------------------------------------------------------------
   // timing and counter constants
   // ---------------------------------------------------------------
   localparam int         MCYCLE_CLKS = 12; // clocks per machine cycle
   localparam logic [3:0] PRE_LAST    = 4'(MCYCLE_CLKS - 1);
   localparam logic [3:0] PRE_ZERO    = 4'h0;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   typedef enum {MD_CAPTURE, MD_RELOAD, MD_UPDOWN, MD_BAUD} t2c_mode_e;
   // mode from control bits and down-count enable
   function automatic t2c_mode_e t2c_mode(input logic [7:0] c, input logic down_count_enable);
      if (c[B_RCLK] || c[B_TRANSMIT_CLOCK_SELECT]) begin
         return MD_BAUD;
      end else if (c[B_CPRL]) begin
         return MD_CAPTURE;
      end else if (down_count_enable) begin
         return MD_UPDOWN;
      end
      return MD_RELOAD;
   endfunction
endpackage

//--- logic/t2c_edge_if.sv
// Purpose: carries one pin sampler's tick, level and edge pulse
// Assumes: tick is one clock long, once per machine cycle
// Notes:   det side samples, user side consumes the edge
`timescale 1ns/10ps
interface t2c_edge_if;
   logic sampleTick;   // machine-cycle sample strobe
   logic pinLevel;     // raw pin level
   logic fallSeen;     // one-cycle falling-edge pulse
   logic sampledLevel; // last sampled level
   modport det  (input sampleTick, input pinLevel, output fallSeen, output sampledLevel);
   modport user (output sampleTick, output pinLevel, input fallSeen, input sampledLevel);
endinterface

//--- logic/t2c_fall_detect.sv
// Purpose: finds a falling edge on a pin sampled once per machine cycle
// Assumes: pin synchronous to clk
// Notes:   edge needs two samples, so pulses lag the pin by up to one machine cycle
`timescale 1ns/10ps
module t2c_fall_detect (
   input wire logic clk,
   input wire logic rst_n,
   t2c_edge_if.det  edge_io
);
   logic samp; // previous machine-cycle sample
   // ---------------------------------------------------------------
   // sampling
   // ---------------------------------------------------------------
   // reset low so a pin held low at start gives no false edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         samp <= 1'b0;
      end else if (edge_io.sampleTick) begin
         samp <= edge_io.pinLevel;
      end
   end
   // high sample then low sample at this tick
   assign edge_io.fallSeen = edge_io.sampleTick & samp & ~edge_io.pinLevel; // R18
   assign edge_io.sampledLevel = samp;
endmodule

//--- logic/t2c_reload_pair.sv
// Purpose: 16-bit capture/reload register pair
// Assumes: byte writes and capture never collide in normal use
// Notes:   a software byte write wins over a capture that cycle
`timescale 1ns/10ps
module t2c_reload_pair
   import t2c_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        writeLow,
   input  wire logic        writeHigh,
   input  wire logic [7:0]  writeData,
   input  wire logic        capture,
   input  wire logic [15:0] captureValue,
   output logic      [15:0] pairValue
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pairValue <= CNT_ZERO;
      end else if (writeLow || writeHigh) begin
         if (writeLow) begin
            pairValue[7:0] <= writeData;
         end
         if (writeHigh) begin
            pairValue[15:8] <= writeData;
         end
      end else if (capture) begin
         pairValue <= captureValue; // R15
      end
   end
endmodule

//--- bench/t2c_pin_model.sv
// Purpose: far-side model of the trigger/direction and external count pins
// Assumes: both pins have pull-ups, so they rest high when nobody pulls them
// Notes:   each requested fall holds the pin low for 24 clocks (two machine
//          cycles); a low under one machine cycle could fall between two samples and be lost
`timescale 1ns/10ps
module t2c_pin_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic trigFall,
   input  wire logic countFall,
   input  wire logic dirLow,
   output logic      triggerDirectionPin,
   output logic      externalCountPin
);
   logic [4:0] trigLeft;  // low clocks left on the trigger pin
   logic [4:0] countLeft; // low clocks left on the count pin
   // ---------------------------------------------------------------
   // low-phase timers, one per pin
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trigLeft  <= 5'h00;
         countLeft <= 5'h00;
      end else begin
         trigLeft  <= trigFall ? 5'h18 : trigLeft - 5'((trigLeft != 5'h00));
         countLeft <= countFall ? 5'h18 : countLeft - 5'((countLeft != 5'h00));
      end
   end
   // pull-up level unless a fall or a down-count hold pulls it low
   assign triggerDirectionPin = (trigLeft == 5'h00) && !dirLow;
   assign externalCountPin    = (countLeft == 5'h00);
endmodule

//--- bench/tb_timer2_control_register.sv
// Purpose: self-checking bench for the timer-2 control register block
// Assumes: strobes one cycle long, read data in the cycle after the strobe
// Notes:   plain register cases sit in a table; timing cases follow it
`timescale 1ns/10ps
module tb_timer2_control_register
   import t2c_pkg::*;
();
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   typedef struct {
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // value written
      logic [7:0] exp;   // value expected back
   } t2c_row_s;
   logic       clk;                 // core clock
   logic       rst_n;               // sync reset
   logic [7:0] regAddr;             // bus address
   logic [7:0] regWdata;            // bus write data
   logic       regWrite;            // write strobe
   logic       regRead;             // read strobe
   logic [7:0] regRdata;            // read data
   logic       triggerDirectionPin; // from pin model
   logic       externalCountPin;    // from pin model
   logic       timer2IntEnable;     // interrupt enable
   logic       timer1Overflow;      // other baud source
   logic       timer2Irq;           // interrupt request
   logic       rxClockTick;         // receive baud pulse
   logic       txClockTick;         // transmit baud pulse
   logic       timer2BaudTick;      // timer-2 baud pulse
   logic       trigFall;            // ask model for a trigger fall
   logic       countFall;           // ask model for a count fall
   logic       dirLow;              // hold trigger low to count down
   logic [7:0] rdVal;               // scratch read value
   int         errTotal;            // mismatches
   int         nChecks;             // comparisons made
   int         cycles;              // timeout counter
   int         baudSeen;            // baud pulses seen
   int         bad;                 // cycles with a wrong baud source
   t2c_row_s   rows [10];           // register table cases
   // ---------------------------------------------------------------
   // design, far-side model, clock
   // ---------------------------------------------------------------
   t2c_timer2_control dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .triggerDirectionPin(triggerDirectionPin), .externalCountPin(externalCountPin),
      .timer2IntEnable(timer2IntEnable), .timer1Overflow(timer1Overflow),
      .timer2Irq(timer2Irq), .rxClockTick(rxClockTick), .txClockTick(txClockTick),
      .timer2BaudTick(timer2BaudTick));
   t2c_pin_model pins (.clk(clk), .rst_n(rst_n), .trigFall(trigFall),
      .countFall(countFall), .dirLow(dirLow), .triggerDirectionPin(triggerDirectionPin),
      .externalCountPin(externalCountPin));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard: whole run needs a few hundred clocks
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         errTotal++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample there
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      rdVal = regRdata;
      chkByte(rdVal, exp, what);
   endtask
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp, input string what);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask
   // one fall on a pin, then enough high time for the next one
   task automatic fall(input bit onTrig);
      @(posedge clk);
      if (onTrig) begin
         trigFall <= 1'b1;
      end else begin
         countFall <= 1'b1;
      end
      @(posedge clk);
      trigFall  <= 1'b0;
      countFall <= 1'b0;
      repeat (48) @(posedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rows = '{'{ADDR_CTRL, 8'hCB, 8'hCB}, '{ADDR_CTRL, 8'h30, 8'h30},
               '{ADDR_MODE, 8'hFF, 8'h03}, '{ADDR_CAPL, 8'h5A, 8'h5A},
               '{ADDR_CAPH, 8'hA5, 8'hA5}, '{ADDR_CNTL, 8'h12, 8'h12},
               '{ADDR_CNTH, 8'h34, 8'h34}, '{8'hCE, 8'h00, 8'h00},
               '{ADDR_CTRL, 8'h00, 8'h00}, '{ADDR_MODE, 8'h00, 8'h00}};
      {rst_n, regWrite, regRead, trigFall, countFall, dirLow, timer1Overflow} = 7'h00;
      {regAddr, regWdata} = 16'h0000;
      timer2IntEnable = 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rdChk(ADDR_CTRL, 8'h00, "ctrl after reset");
      rdChk(ADDR_MODE, 8'h00, "mode after reset");
      for (int i = 0; i < 10; i++) begin
         wr(rows[i].addr, rows[i].wdata);
         rdChk(rows[i].addr, rows[i].exp, "readback");
      end
      // timer-1 source for the side whose select bit is clear
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, i ? 8'h10 : 8'h20);
         @(posedge clk);
         timer1Overflow <= 1'b1;
         @(posedge clk);
         #1;
         chkBit(rxClockTick, 1'(i), "rx source");
         chkBit(txClockTick, 1'(1 - i), "tx source");
         timer1Overflow <= 1'b0;
      end
      // reload on overflow in timer mode, flag sticks until cleared
      // all-ones pair: reload keeps FFFF where a plain wrap would give 0000
      wr(ADDR_CAPL, 8'hFF);
      wr(ADDR_CAPH, 8'hFF);
      wr(ADDR_CNTL, 8'hFF);
      wr(ADDR_CNTH, 8'hFF);
      wr(ADDR_CTRL, 8'h04);
      repeat (40) @(posedge clk);
      rdChk(ADDR_CTRL, 8'h84, "overflow flag");
      chkBit(timer2Irq, 1'b1, "overflow irq");
      // stop first: a running overflow would win over the clear
      wr(ADDR_CTRL, 8'h80);
      wr(ADDR_CTRL, 8'h00);
      rdChk(ADDR_CTRL, 8'h00, "flag cleared");
      rdChk(ADDR_CNTH, 8'hFF, "reloaded high byte");
      rdChk(ADDR_CNTL, rdVal, "count frozen");
      repeat (30) @(posedge clk);
      chkByte(regRdata, 8'h00, "rdata after its cycle");
      rdChk(ADDR_CNTL, rdVal, "count stopped");
      // serial clock mode: capture bit ignored, no overflow flag
      wr(ADDR_CAPL, 8'hF0);
      wr(ADDR_CNTL, 8'hF0);
      wr(ADDR_CTRL, 8'h35);
      {baudSeen, bad} = 64'h0;
      repeat (100) begin
         @(posedge clk);
         #1;
         baudSeen += int'(timer2BaudTick === 1'b1);
         bad += int'(rxClockTick !== timer2BaudTick || txClockTick !== timer2BaudTick);
      end
      chkBit(baudSeen != 0 && bad == 0, 1'b1, "timer-2 baud pulses");
      rdChk(ADDR_CTRL, 8'h35, "no flag in serial mode");
      wr(ADDR_CTRL, 8'h00);
      rdChk(ADDR_CNTH, 8'hFF, "forced reload");
      // capture on a trigger fall, then a second fall ignored with the trigger disabled
      wr(ADDR_CNTL, 8'h34);
      wr(ADDR_CNTH, 8'h12);
      wr(ADDR_CTRL, 8'h09);
      fall(1'b1);
      rdChk(ADDR_CAPL, 8'h34, "capture low");
      rdChk(ADDR_CAPH, 8'h12, "capture high");
      rdChk(ADDR_CTRL, 8'h49, "external flag");
      chkBit(timer2Irq, 1'b1, "external irq");
      timer2IntEnable <= 1'b0;
      @(posedge clk);
      #1;
      chkBit(timer2Irq, 1'b0, "irq masked");
      timer2IntEnable <= 1'b1;
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_CAPL, 8'h00);
      fall(1'b1);
      rdChk(ADDR_CAPL, 8'h00, "trigger ignored");
      rdChk(ADDR_CTRL, 8'h01, "no external flag");
      // event counting on the count pin only
      wr(ADDR_CNTL, 8'h00);
      wr(ADDR_CNTH, 8'h00);
      wr(ADDR_CTRL, 8'h06);
      fall(1'b0);
      rdChk(ADDR_CNTL, 8'h01, "one event counted");
      // up/down mode: up overflow, flag toggles without interrupt
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CAPL, 8'h00);
      wr(ADDR_CAPH, 8'h00);
      wr(ADDR_CNTL, 8'hFF);
      wr(ADDR_CNTH, 8'hFF);
      wr(ADDR_CTRL, 8'h04);
      repeat (20) @(posedge clk);
      rdChk(ADDR_CTRL, 8'hC4, "up overflow");
      wr(ADDR_CTRL, 8'h40);
      #1;
      chkBit(timer2Irq, 1'b0, "no irq in up/down");
      // down: count equal to pair underflows to all ones
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNTL, 8'h00);
      wr(ADDR_CNTH, 8'h00);
      dirLow <= 1'b1;
      repeat (30) @(posedge clk);
      wr(ADDR_CTRL, 8'h04);
      repeat (20) @(posedge clk);
      rdChk(ADDR_CTRL, 8'hC4, "underflow flags");
      rdChk(ADDR_CNTH, 8'hFF, "underflow reload");
      // reset in mid-run clears everything again
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      dirLow <= 1'b0;
      rdChk(ADDR_CTRL, 8'h00, "ctrl after second reset");
      rdChk(ADDR_MODE, 8'h00, "mode after second reset");
      summarize();
   end
endmodule
